// ### core/serial_regs_pkg.sv
// Constants for the serial control port register bank
package serial_regs_pkg;

  localparam int unsigned ADDR_W = 13;

  localparam logic [12:0] SERIAL_PORT_SETUP_ADDR    = 13'h0000;
  localparam logic [12:0] DEVICE_VARIANT_CODE_ADDR  = 13'h0003;
  localparam logic [12:0] READBACK_SOURCE_ADDR      = 13'h0004;
  localparam logic [12:0] OSCILLATOR_DIVIDE_ADDR    = 13'h01E0;
  localparam logic [12:0] CLOCK_SOURCE_ADDR         = 13'h01E1;
  localparam logic [12:0] POWERDOWN_SYNC_ADDR       = 13'h0230;
  localparam logic [12:0] SYSTEM_RESERVED_ADDR      = 13'h0231;
  localparam logic [12:0] REGISTER_UPDATE_ADDR      = 13'h0232;

  localparam logic [7:0] SERIAL_PORT_SETUP_RST = 8'h18;
  localparam logic [7:0] OSCILLATOR_DIVIDE_RST = 8'h02;
  localparam logic [7:0] CLOCK_SOURCE_RST      = 8'h00;
  localparam logic [7:0] POWERDOWN_SYNC_RST    = 8'h00;
  localparam logic [7:0] SYSTEM_RESERVED_RST   = 8'h00;
  localparam logic [7:0] REGISTER_UPDATE_RST   = 8'h00;

  // Implemented bits; the rest read as zero
  localparam logic [7:0] OSCILLATOR_DIVIDE_MASK = 8'h07;
  localparam logic [7:0] CLOCK_SOURCE_MASK      = 8'h1F;
  localparam logic [7:0] POWERDOWN_SYNC_MASK    = 8'h07;
  localparam logic [7:0] SYSTEM_RESERVED_MASK   = 8'h00;

  localparam int unsigned FOUR_WIRE_SELECT_BIT = 0;
  localparam int unsigned LSB_FIRST_BIT        = 1;
  localparam int unsigned SOFT_RESET_BIT       = 2;
  localparam int unsigned LONG_INSTR_BIT       = 3;
  localparam int unsigned READBACK_ACTIVE_BIT  = 0;
  localparam int unsigned UPDATE_ALL_BIT       = 0;

  localparam int unsigned INSTR_BITS   = 16;
  localparam int unsigned DATA_BITS    = 8;
  localparam int unsigned RW_BIT       = 15;
  localparam int unsigned LEN_HI_BIT   = 14;
  localparam int unsigned LEN_LO_BIT   = 13;
  localparam logic [1:0]  LEN_STREAM   = 2'h3;

  localparam int unsigned SYNC_STAGES  = 3;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_DONE  = 4'b1000
  } port_state_type;

endpackage

// ### core/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned     WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] stable_out
);

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q     <= RESET_VAL;
      s2_q       <= RESET_VAL;
      s3_q       <= RESET_VAL;
      stable_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
      // A level counts only once two later stages agree
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          stable_out[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// ### core/serial_port_config_regs.sv
// Serial control port slave with buffered and active register bank
`timescale 1ns/1ns
module serial_port_config_regs #(
  // Arbitrary neutral value
  parameter logic [7:0] VARIANT_CODE = 8'h5A
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       port_sclk_in,
  input  wire logic       port_cs_b_in,
  input  wire logic       port_sdio_in,
  output logic            port_sdio_out,
  output logic            port_sdio_oe_out,
  output logic            serial_out_pin_out,
  output logic            serial_out_pin_oe_out,
  output logic [7:0]      oscillator_divide_out,
  output logic [7:0]      clock_source_out,
  output logic [7:0]      powerdown_sync_out,
  output logic            soft_reset_out
);

  logic                          rst_meta_q;
  logic                          rst_b_q;
  logic [2:0]                    pins_s;
  logic                          cs_b_s;
  logic                          sclk_s;
  logic                          sdio_s;
  logic                          sclk_prev_q;
  logic                          sclk_rise;
  logic                          sclk_fall;
  serial_regs_pkg::port_state_type state_q;
  logic [3:0]                    bit_cnt_q;
  logic [15:0]                   shift_q;
  logic [15:0]                   shift_d;
  logic                          rd_q;
  logic [1:0]                    len_q;
  logic [1:0]                    bytes_q;
  logic [12:0]                   addr_q;
  logic [12:0]                   addr_d;
  logic [7:0]                    tx_q;
  logic [7:0]                    rx_byte;
  logic                          instr_done;
  logic                          byte_done;
  logic                          wr_fire;
  logic [7:0]                    setup_q;
  logic                          rb_active_q;
  logic [7:0]                    div_buf_q;
  logic [7:0]                    src_buf_q;
  logic [7:0]                    pds_buf_q;
  logic                          update_q;
  logic                          lsb_first;
  logic                          four_wire;
  logic                          soft_rst;

  // Reset release through two flops
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_b_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_b_q    <= rst_meta_q;
    end
  end

  pin_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h4)
  ) u_pin_sync (
    .clk_in     (sys_clk_in),
    .rst_b_in   (rst_b_q),
    .async_in   ({port_cs_b_in, port_sclk_in, port_sdio_in}),
    .stable_out (pins_s)
  );

  assign cs_b_s    = pins_s[2];
  assign sclk_s    = pins_s[1];
  assign sdio_s    = pins_s[0];
  assign lsb_first = setup_q[serial_regs_pkg::LSB_FIRST_BIT];
  assign four_wire = setup_q[serial_regs_pkg::FOUR_WIRE_SELECT_BIT];
  assign soft_rst  = setup_q[serial_regs_pkg::SOFT_RESET_BIT];

  always_ff @(posedge sys_clk_in or negedge rst_b_q) begin
    if (!rst_b_q) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_b_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_b_s;

  assign shift_d = lsb_first ? {sdio_s, shift_q[15:1]} : {shift_q[14:0], sdio_s};
  assign rx_byte = lsb_first ? shift_d[15:8] : shift_d[7:0];
  assign addr_d  = lsb_first ? addr_q + 13'h0001 : addr_q - 13'h0001;

  assign instr_done = sclk_rise && (state_q == serial_regs_pkg::ST_INSTR)
                      && (bit_cnt_q == 4'(serial_regs_pkg::INSTR_BITS - 1));
  assign byte_done  = sclk_rise && (state_q == serial_regs_pkg::ST_DATA)
                      && (bit_cnt_q == 4'(serial_regs_pkg::DATA_BITS - 1));
  assign wr_fire    = byte_done && !rd_q;

  function automatic logic [7:0] pick(input logic [7:0] buf_v, input logic [7:0] act_v,
                                      input logic sel);
    return sel ? act_v : buf_v;
  endfunction

  function automatic logic [7:0] read_value(input logic [12:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == serial_regs_pkg::SERIAL_PORT_SETUP_ADDR) begin
      v = setup_q;
    end else if (a == serial_regs_pkg::DEVICE_VARIANT_CODE_ADDR) begin
      v = VARIANT_CODE;
    end else if (a == serial_regs_pkg::READBACK_SOURCE_ADDR) begin
      v = {7'h00, rb_active_q};
    end else if (a == serial_regs_pkg::OSCILLATOR_DIVIDE_ADDR) begin
      v = pick(div_buf_q, oscillator_divide_out, rb_active_q);
    end else if (a == serial_regs_pkg::CLOCK_SOURCE_ADDR) begin
      v = pick(src_buf_q, clock_source_out, rb_active_q);
    end else if (a == serial_regs_pkg::POWERDOWN_SYNC_ADDR) begin
      v = pick(pds_buf_q, powerdown_sync_out, rb_active_q);
    end else if (a == serial_regs_pkg::REGISTER_UPDATE_ADDR) begin
      v = {7'h00, update_q};
    end
    return v;
  endfunction

  // Transfer sequencing
  always_ff @(posedge sys_clk_in or negedge rst_b_q) begin
    if (!rst_b_q) begin
      state_q   <= serial_regs_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 16'h0000;
      rd_q      <= 1'b0;
      len_q     <= 2'h0;
      bytes_q   <= 2'h0;
      addr_q    <= 13'h0000;
    end else if (cs_b_s) begin
      state_q   <= serial_regs_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
    end else begin
      case (state_q)
        serial_regs_pkg::ST_IDLE: begin
          state_q   <= serial_regs_pkg::ST_INSTR;
          bit_cnt_q <= 4'h0;
        end
        serial_regs_pkg::ST_INSTR: begin
          if (sclk_rise) begin
            shift_q   <= shift_d;
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (instr_done) begin
            state_q   <= serial_regs_pkg::ST_DATA;
            bit_cnt_q <= 4'h0;
            rd_q      <= shift_d[serial_regs_pkg::RW_BIT];
            len_q     <= shift_d[serial_regs_pkg::LEN_HI_BIT:serial_regs_pkg::LEN_LO_BIT];
            bytes_q   <= 2'h0;
            addr_q    <= shift_d[serial_regs_pkg::ADDR_W-1:0];
          end
        end
        serial_regs_pkg::ST_DATA: begin
          if (sclk_rise) begin
            shift_q   <= shift_d;
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (byte_done) begin
            bit_cnt_q <= 4'h0;
            addr_q    <= addr_d;
            bytes_q   <= bytes_q + 2'h1;
            if ((len_q != serial_regs_pkg::LEN_STREAM) && (bytes_q == len_q)) begin
              state_q <= serial_regs_pkg::ST_DONE;
            end
          end
        end
        serial_regs_pkg::ST_DONE: begin
          state_q <= serial_regs_pkg::ST_DONE;
        end
        default: begin
          state_q <= serial_regs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Read data: loaded on the last rising edge, shifted out on falling edges
  always_ff @(posedge sys_clk_in or negedge rst_b_q) begin
    if (!rst_b_q) begin
      tx_q                  <= 8'h00;
      port_sdio_out         <= 1'b0;
      port_sdio_oe_out      <= 1'b0;
      serial_out_pin_out    <= 1'b0;
      serial_out_pin_oe_out <= 1'b0;
    end else if (cs_b_s) begin
      port_sdio_oe_out      <= 1'b0;
      serial_out_pin_oe_out <= 1'b0;
    end else if (instr_done) begin
      tx_q <= read_value(shift_d[serial_regs_pkg::ADDR_W-1:0]);
    end else if (byte_done) begin
      tx_q <= read_value(addr_d);
    end else if (sclk_fall && rd_q && (state_q == serial_regs_pkg::ST_DATA)) begin
      tx_q <= lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
      if (four_wire) begin
        serial_out_pin_out    <= lsb_first ? tx_q[0] : tx_q[7];
        serial_out_pin_oe_out <= 1'b1;
      end else begin
        port_sdio_out    <= lsb_first ? tx_q[0] : tx_q[7];
        port_sdio_oe_out <= 1'b1;
      end
    end
  end

  // Port setup register; soft reset leaves it writable so it can be cleared
  always_ff @(posedge sys_clk_in or negedge rst_b_q) begin
    if (!rst_b_q) begin
      setup_q <= serial_regs_pkg::SERIAL_PORT_SETUP_RST;
    end else if (wr_fire && (addr_q == serial_regs_pkg::SERIAL_PORT_SETUP_ADDR)) begin
      setup_q <= rx_byte;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_q) begin
    if (!rst_b_q) begin
      rb_active_q <= 1'b0;
      div_buf_q   <= serial_regs_pkg::OSCILLATOR_DIVIDE_RST;
      src_buf_q   <= serial_regs_pkg::CLOCK_SOURCE_RST;
      pds_buf_q   <= serial_regs_pkg::POWERDOWN_SYNC_RST;
    end else if (soft_rst) begin
      rb_active_q <= 1'b0;
      div_buf_q   <= serial_regs_pkg::OSCILLATOR_DIVIDE_RST;
      src_buf_q   <= serial_regs_pkg::CLOCK_SOURCE_RST;
      pds_buf_q   <= serial_regs_pkg::POWERDOWN_SYNC_RST;
    end else if (wr_fire) begin
      if (addr_q == serial_regs_pkg::READBACK_SOURCE_ADDR) begin
        rb_active_q <= rx_byte[serial_regs_pkg::READBACK_ACTIVE_BIT];
      end else if (addr_q == serial_regs_pkg::OSCILLATOR_DIVIDE_ADDR) begin
        div_buf_q <= rx_byte & serial_regs_pkg::OSCILLATOR_DIVIDE_MASK;
      end else if (addr_q == serial_regs_pkg::CLOCK_SOURCE_ADDR) begin
        src_buf_q <= rx_byte & serial_regs_pkg::CLOCK_SOURCE_MASK;
      end else if (addr_q == serial_regs_pkg::POWERDOWN_SYNC_ADDR) begin
        pds_buf_q <= rx_byte & serial_regs_pkg::POWERDOWN_SYNC_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_q) begin
    if (!rst_b_q) begin
      update_q <= 1'b0;
    end else begin
      update_q <= wr_fire && !soft_rst
                  && (addr_q == serial_regs_pkg::REGISTER_UPDATE_ADDR)
                  && rx_byte[serial_regs_pkg::UPDATE_ALL_BIT];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_q) begin
    if (!rst_b_q) begin
      oscillator_divide_out <= serial_regs_pkg::OSCILLATOR_DIVIDE_RST;
      clock_source_out      <= serial_regs_pkg::CLOCK_SOURCE_RST;
      powerdown_sync_out    <= serial_regs_pkg::POWERDOWN_SYNC_RST;
    end else if (soft_rst) begin
      oscillator_divide_out <= serial_regs_pkg::OSCILLATOR_DIVIDE_RST;
      clock_source_out      <= serial_regs_pkg::CLOCK_SOURCE_RST;
      powerdown_sync_out    <= serial_regs_pkg::POWERDOWN_SYNC_RST;
    end else if (update_q) begin
      oscillator_divide_out <= div_buf_q;
      clock_source_out      <= src_buf_q;
      powerdown_sync_out    <= pds_buf_q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_q) begin
    if (!rst_b_q) begin
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= soft_rst;
    end
  end

endmodule

// ### verif/serial_regs_monitor.sv
// Port-level checker for the serial register bank
`timescale 1ns/1ns
module serial_regs_monitor (
  input wire logic       sys_clk_in,
  input wire logic       rst_b_in,
  input wire logic       port_sclk_in,
  input wire logic       port_cs_b_in,
  input wire logic       port_sdio_out,
  input wire logic       port_sdio_oe_out,
  input wire logic       serial_out_pin_out,
  input wire logic       serial_out_pin_oe_out,
  input wire logic [7:0] oscillator_divide_out,
  input wire logic [7:0] clock_source_out,
  input wire logic [7:0] powerdown_sync_out,
  input wire logic       soft_reset_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence cs_idle;
    port_cs_b_in [*8];
  endsequence
  // Read bits only move after a serial clock fall
  sequence sclk_high;
    port_sclk_in [*7];
  endsequence
  one_driver_a: assert property (!(port_sdio_oe_out && serial_out_pin_oe_out))
    else $error("both read pins driven");
  idle_release_a: assert property (cs_idle |-> !port_sdio_oe_out && !serial_out_pin_oe_out)
    else $error("read pin driven while deselected");
  sdio_hold_a: assert property (port_sdio_oe_out and sclk_high |=> $stable(port_sdio_out))
    else $error("shared pin changed while clock high");
  sdo_hold_a: assert property (serial_out_pin_oe_out and sclk_high |=>
    $stable(serial_out_pin_out))
    else $error("separate pin changed while clock high");
  active_hold_a: assert property (cs_idle |=>
    $stable({oscillator_divide_out, clock_source_out, powerdown_sync_out}))
    else $error("active copy changed without transfer");
  softrst_hold_a: assert property (cs_idle |=> $stable(soft_reset_out))
    else $error("soft reset changed without transfer");
  softrst_default_a: assert property (soft_reset_out [*3] |->
    oscillator_divide_out == serial_regs_pkg::OSCILLATOR_DIVIDE_RST &&
    clock_source_out == serial_regs_pkg::CLOCK_SOURCE_RST &&
    powerdown_sync_out == serial_regs_pkg::POWERDOWN_SYNC_RST)
    else $error("defaults lost in reset");
  unused_bits_a: assert property (
    (oscillator_divide_out & ~serial_regs_pkg::OSCILLATOR_DIVIDE_MASK) == 8'h00 &&
    (clock_source_out & ~serial_regs_pkg::CLOCK_SOURCE_MASK) == 8'h00 &&
    (powerdown_sync_out & ~serial_regs_pkg::POWERDOWN_SYNC_MASK) == 8'h00)
    else $error("unimplemented active bit set");
endmodule
bind serial_port_config_regs serial_regs_monitor u_mon (.sys_clk_in, .rst_b_in, .port_sclk_in,
  .port_cs_b_in, .port_sdio_out, .port_sdio_oe_out, .serial_out_pin_out, .serial_out_pin_oe_out,
  .oscillator_divide_out, .clock_source_out, .powerdown_sync_out, .soft_reset_out);

// ### verif/serial_host_model.sv
// Host controller model driving the serial control port
`timescale 1ns/1ns
module serial_host_model (
  input wire logic clk_in,
  input wire logic lsb_in,
  input wire logic four_in,
  input wire logic dev_sdio_in,
  input wire logic dev_sdio_oe_in,
  input wire logic dev_so_in,
  output logic     sclk_out,
  output logic     cs_b_out,
  output logic     sdio_out
);
  logic drv = 1'b1;
  logic hb = 1'b0;
  logic fb = 1'b0;
  initial sclk_out = 1'b0;
  initial cs_b_out = 1'b1;
  // Released line shows the inverse of the last bit, not a stale copy
  assign sdio_out = drv ? hb : (dev_sdio_oe_in ? dev_sdio_in : fb);
  task automatic gap();
    repeat (8) @(posedge clk_in);
    #1;
  endtask
  task automatic xfer(input logic rd, input logic [12:0] a, input int n, inout logic [23:0] d);
    logic [15:0] ins;
    logic [7:0]  b;
    ins = {rd, 2'(n - 1), a};
    cs_b_out = 1'b0;
    for (int i = 0; i < 16; i++) begin
      drv = 1'b1;
      hb = lsb_in ? ins[i] : ins[15-i];
      gap();
      sclk_out = 1'b1;
      gap();
      sclk_out = 1'b0;
    end
    if (rd) begin
      drv = 1'b0;
      fb = ~hb;
    end
    for (int k = 0; k < n; k++) begin
      b = d[8*k+:8];
      for (int i = 0; i < 8; i++) begin
        if (!rd) hb = lsb_in ? b[i] : b[7-i];
        gap();
        sclk_out = 1'b1;
        if (rd) b[lsb_in ? i : 7-i] = four_in ? dev_so_in : sdio_out;
        gap();
        sclk_out = 1'b0;
      end
      d[8*k+:8] = b;
    end
    gap();
    cs_b_out = 1'b1;
    drv = 1'b0;
    fb = ~hb;
    gap();
  endtask
endmodule

// ### verif/serial_port_config_regs_tb_top.sv
// Self-checking bench for the serial register bank
`timescale 1ns/1ns
module serial_port_config_regs_tb_top;
  localparam logic [7:0]  CODE = 8'hA5; // Arbitrary variant code
  localparam logic [12:0] ADDR [3] = '{serial_regs_pkg::OSCILLATOR_DIVIDE_ADDR,
    serial_regs_pkg::CLOCK_SOURCE_ADDR, serial_regs_pkg::POWERDOWN_SYNC_ADDR};
  localparam logic [7:0]  MSK [3] = '{8'h07, 8'h1F, 8'h07};
  localparam logic [7:0]  RST [3] = '{8'h02, 8'h00, 8'h00};
  logic       sys_clk_in = 0, rst_b_in = 0, lsb = 0, four = 0;
  logic       port_sclk_in, port_cs_b_in, port_sdio_in, port_sdio_out, port_sdio_oe_out;
  logic       serial_out_pin_out, serial_out_pin_oe_out, soft_reset_out;
  logic [7:0] oscillator_divide_out, clock_source_out, powerdown_sync_out;
  int         fails = 0, n_checks = 0, cyc = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  serial_port_config_regs #(.VARIANT_CODE(CODE)) DUT (.sys_clk_in, .rst_b_in, .port_sclk_in,
    .port_cs_b_in, .port_sdio_in, .port_sdio_out, .port_sdio_oe_out, .serial_out_pin_out,
    .serial_out_pin_oe_out, .oscillator_divide_out, .clock_source_out, .powerdown_sync_out,
    .soft_reset_out);
  serial_host_model host (.clk_in(sys_clk_in), .lsb_in(lsb), .four_in(four),
    .dev_sdio_in(port_sdio_out), .dev_sdio_oe_in(port_sdio_oe_out),
    .dev_so_in(serial_out_pin_out), .sclk_out(port_sclk_in), .cs_b_out(port_cs_b_in),
    .sdio_out(port_sdio_in));
  function automatic logic [7:0] mirror(input logic [3:0] n);
    return {n[0], n[1], n[2], n[3], n};
  endfunction
  function automatic logic [7:0] act(input int i);
    return i == 0 ? oscillator_divide_out : (i == 1 ? clock_source_out : powerdown_sync_out);
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    logic [23:0] d;
    d = {16'h0000, v};
    host.xfer(1'b0, a, 1, d);
  endtask
  task automatic rdchk(input string what, input logic [12:0] a, input logic [7:0] exp);
    logic [23:0] d;
    d = 24'h00_0000;
    host.xfer(1'b1, a, 1, d);
    check(what, d[7:0], exp);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 15k cycles the sequence needs
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0]  e [3];
    logic [23:0] d;
    int          s;
    s = $urandom(32'h3abc);
    repeat (2) @(posedge sys_clk_in);
    #1 rst_b_in = 1'b1;
    repeat (10) @(posedge sys_clk_in);
    #1;
    for (int i = 0; i < 3; i++) check("active reset", act(i), RST[i]);
    rdchk("setup", 13'h0000, 8'h18);
    wr(13'h0003, ~CODE);
    rdchk("variant", 13'h0003, CODE);
    rdchk("readback", 13'h0004, 8'h00);
    wr(13'h0231, 8'hFF);
    rdchk("reserved", 13'h0231, 8'h00);
    rdchk("unmapped", 13'h0100, 8'h00);
    for (int i = 0; i < 3; i++) begin
      e[i] = (i == 2) ? 8'hFF : 8'($urandom);
      wr(ADDR[i], e[i]);
      check("active held", act(i), RST[i]);
      rdchk("buffer", ADDR[i], e[i] & MSK[i]);
    end
    wr(13'h0004, 8'h01);
    rdchk("active view", ADDR[0], RST[0]);
    wr(13'h0232, 8'h01);
    for (int i = 0; i < 3; i++) check("updated", act(i), e[i] & MSK[i]);
    rdchk("update clear", 13'h0232, 8'h00);
    rdchk("active view", ADDR[1], e[1] & MSK[1]);
    wr(13'h0004, 8'h00);
    d = 24'h00_0615;
    host.xfer(1'b0, ADDR[1], 2, d);
    rdchk("msb first", ADDR[1], 8'h15);
    rdchk("decrement", ADDR[0], 8'h06);
    // Three-byte read walks down into an unmapped address
    d = 24'h00_0000;
    host.xfer(1'b1, ADDR[1], 3, d);
    check("stream 0", d[7:0], 8'h15);
    check("stream 1", d[15:8], 8'h06);
    check("stream 2", d[23:16], 8'h00);
    wr(13'h0000, mirror(4'hA));
    lsb = 1'b1;
    d = 24'h00_0B05;
    host.xfer(1'b0, ADDR[0], 2, d);
    rdchk("lsb first", ADDR[0], 8'h05);
    rdchk("increment", ADDR[1], 8'h0B);
    wr(13'h0000, mirror(4'hB));
    four = 1'b1;
    rdchk("four wire", ADDR[1], 8'h0B);
    wr(13'h0000, mirror(4'h8));
    lsb = 1'b0;
    four = 1'b0;
    rdchk("three wire", 13'h0000, 8'h18);
    wr(13'h0232, 8'h01);
    check("updated", act(0), 8'h05);
    check("updated", act(1), 8'h0B);
    check("updated", act(2), e[2] & MSK[2]);
    wr(13'h0000, mirror(4'hC));
    check("soft reset", {7'h00, soft_reset_out}, 8'h01);
    wr(ADDR[0], 8'h07);
    for (int i = 0; i < 3; i++) check("reset active", act(i), RST[i]);
    wr(13'h0000, mirror(4'h8));
    check("soft done", {7'h00, soft_reset_out}, 8'h00);
    rdchk("reset buffer", ADDR[0], RST[0]);
    rdchk("reset buffer", ADDR[1], RST[1]);
    print_verdict();
  end
endmodule
